// ==== include/noproto_pkg.sv ====
// Constants, register map and state codes of the no-protocol serial unit
`default_nettype none
package noproto_pkg;
    localparam int          CLK_HZ      = 50_000_000;
    localparam int          BAUD_RST    = 9600;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_RST);
    localparam logic [15:0] GAP_RST     = 16'h0000;
    localparam logic [31:0] CFG_RST     = 32'h0000_0000;
    // Byte offsets on the APB
    localparam logic [11:0] CFG_OFS     = 12'h000;
    localparam logic [11:0] BAUD_OFS    = 12'h004;
    localparam logic [11:0] GAP_OFS     = 12'h008;
    localparam logic [11:0] CMD_OFS     = 12'h00C;
    localparam logic [11:0] STAT_OFS    = 12'h010;
    localparam logic [2:0]  BUF_PAGE    = 3'h1;
    localparam int          BUF_WORDS   = 128;
    // Configuration fields
    localparam int          CFG_SCODE   = 0;
    localparam int          CFG_SEN     = 8;
    localparam int          CFG_EMODE   = 9;
    localparam int          CFG_ECODE   = 11;
    localparam int          CFG_NOPROTO = 19;
    localparam int          CFG_PAR_EN  = 23;
    localparam int          CFG_PAR_ODD = 24;
    localparam int          CFG_TWO_STP = 25;
    localparam int          CFG_SEVEN   = 26;
    localparam logic [1:0]  END_NONE    = 2'h0;
    localparam logic [1:0]  END_CRLF    = 2'h1;
    localparam logic [1:0]  END_BYTE    = 2'h2;
    localparam logic [7:0]  CR_BYTE     = 8'h0D;
    localparam logic [7:0]  LF_BYTE     = 8'h0A;
    // Command word fields
    localparam int          CMD_RECV    = 31;
    localparam int          CMD_N       = 16;
    localparam logic [8:0]  N_MAX       = 9'h100;
    localparam logic [3:0]  ORDER_MAX   = 4'h1;
    localparam logic [3:0]  PORT_MAX    = 4'h3;
    localparam logic [3:0]  HS_MAX      = 4'h3;
    localparam logic [3:0]  HS_RS       = 4'h1;
    localparam logic [3:0]  HS_ER       = 4'h2;
    localparam logic [3:0]  HS_BOTH     = 4'h3;
    localparam logic [9:0]  LINE_MAX    = 10'h103;
    // Status fields
    localparam int          ST_ERR      = 0;
    localparam int          ST_BUSY     = 1;
    localparam int          ST_RXDONE   = 2;
    localparam int          ST_RXCNT    = 16;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_HEAD = 6'b000010,
        S_BODY = 6'b000100,
        S_TAIL = 6'b001000,
        S_GAP  = 6'b010000,
        S_RX   = 6'b100000
    } state_t;
endpackage : noproto_pkg
`default_nettype wire

// ==== design/serial_byte_tx.sv ====
// Byte serialiser: start bit, 7 or 8 data bits, optional parity, 1 or 2 stops
`timescale 1ns/10ps
`default_nettype none
module serial_byte_tx
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [15:0] baud_div,
    input  wire logic        seven_bits,
    input  wire logic        parity_en,
    input  wire logic        parity_odd,
    input  wire logic        two_stop,
    input  wire logic        start,
    input  wire logic [7:0]  data,
    output logic             txd,
    output logic             busy
);
    typedef struct packed {
        logic        busy;
        logic [15:0] tick;
        logic [11:0] shift;
        logic [3:0]  left;
    } ser_t;

    ser_t s_reg;
    ser_t s_next;

    always_comb
    begin
        logic [11:0] v;
        logic [3:0]  db;
        logic        p;
        v      = 12'hFFF;
        db     = seven_bits ? 4'h7 : 4'h8;
        p      = ^(data & {~seven_bits, 7'h7F}) ^ parity_odd;
        s_next = s_reg;
        v[0]   = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (4'(i) < db)
                v[i + 1] = data[i];
        end
        if (parity_en)
            v[db + 4'h1] = p;
        if (!s_reg.busy)
        begin
            if (start)
            begin
                s_next.busy  = 1'b1;
                s_next.shift = v;
                s_next.tick  = 16'h0000;
                s_next.left  = 4'(db + {3'h0, parity_en} + {3'h0, two_stop} + 4'h2);
            end
        end
        else if (s_reg.tick + 16'h0001 >= baud_div)
        begin
            s_next.tick  = 16'h0000;
            s_next.shift = {1'b1, s_reg.shift[11:1]};
            s_next.left  = s_reg.left - 4'h1;
            if (s_reg.left == 4'h1)
                s_next.busy = 1'b0;
        end
        else
            s_next.tick = s_reg.tick + 16'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            s_reg <= '{busy: 1'b0, tick: 16'h0000, shift: 12'hFFF, left: 4'h0};
        else
            s_reg <= s_next;
    end

    assign txd  = s_reg.shift[0];
    assign busy = s_reg.busy;
endmodule : serial_byte_tx
`default_nettype wire

// ==== design/noproto_serial_send_receive.sv ====
// No-protocol send/receive engine with APB registers and word buffer
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module noproto_serial_send_receive
#(
    parameter int PORTS = 4
)
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [PORTS-1:0] send_ready,
    input  wire logic             rx_valid,
    input  wire logic [7:0]       rx_data,
    output logic      [PORTS-1:0] txd,
    output logic      [PORTS-1:0] rs,
    output logic      [PORTS-1:0] er,
    output logic                  operation_error_flag
);
    typedef struct packed {
        logic [31:0]         cfg;
        logic [15:0]         baud;
        logic [15:0]         gap;
        logic [15:0]         ctrl;
        logic [8:0]          n;
        noproto_pkg::state_t st;
        logic [8:0]          bi;
        logic                tidx;
        logic [15:0]         gcnt;
        logic                err;
        logic                rxdone;
        logic [8:0]          rxcnt;
        logic                pready;
        logic [31:0]         prdata;
        logic                pslverr;
        logic                ser_start;
        logic [7:0]          ser_byte;
        logic [PORTS-1:0]    txd;
        logic [PORTS-1:0]    rs;
        logic [PORTS-1:0]    er;
    } core_t;

    core_t c_reg;
    core_t c_next;

    localparam int BUF_WORDS = noproto_pkg::BUF_WORDS;

    logic [7:0] mem_hi [BUF_WORDS];
    logic [7:0] mem_lo [BUF_WORDS];
    logic       ser_txd;
    logic       ser_busy;

    function automatic logic is_buf(input logic [11:0] a);
        is_buf = (a[11:9] == noproto_pkg::BUF_PAGE);
    endfunction : is_buf

    function automatic logic is_reg(input logic [11:0] a);
        is_reg = (a == noproto_pkg::CFG_OFS) || (a == noproto_pkg::BAUD_OFS)
              || (a == noproto_pkg::GAP_OFS) || (a == noproto_pkg::CMD_OFS)
              || (a == noproto_pkg::STAT_OFS);
    endfunction : is_reg

    serial_byte_tx u_ser
    (
        .clk        (clk),
        .nrst       (nrst),
        .baud_div   (c_reg.baud),
        .seven_bits (c_reg.cfg[noproto_pkg::CFG_SEVEN]),
        .parity_en  (c_reg.cfg[noproto_pkg::CFG_PAR_EN]),
        .parity_odd (c_reg.cfg[noproto_pkg::CFG_PAR_ODD]),
        .two_stop   (c_reg.cfg[noproto_pkg::CFG_TWO_STP]),
        .start      (c_reg.ser_start),
        .data       (c_reg.ser_byte),
        .txd        (ser_txd),
        .busy       (ser_busy)
    );

    logic       wr_acc;
    logic       setup;
    logic       cmd_wr;
    logic [1:0] emode;
    logic [7:0] scode;
    logic [7:0] ecode;
    logic [3:0] order_f;
    logic [1:0] port_sel;
    logic [3:0] hs_f;
    logic       can_issue;
    logic [8:0] bi_inc;
    logic [8:0] rx_inc;
    logic       rx_wr;
    logic [7:0] body_byte;

    assign wr_acc    = psel & penable & pwrite & c_reg.pready;
    assign setup     = psel & ~penable;
    assign cmd_wr    = wr_acc & (paddr == noproto_pkg::CMD_OFS);
    assign emode     = c_reg.cfg[noproto_pkg::CFG_EMODE +: 2];
    assign scode     = c_reg.cfg[noproto_pkg::CFG_SCODE +: 8];
    assign ecode     = c_reg.cfg[noproto_pkg::CFG_ECODE +: 8];
    assign order_f   = c_reg.ctrl[3:0];
    assign port_sel  = c_reg.ctrl[9:8];
    assign hs_f      = c_reg.ctrl[7:4];
    assign can_issue = ~c_reg.ser_start & ~ser_busy;
    assign bi_inc    = 9'(c_reg.bi + 9'h001);
    assign rx_inc    = 9'(c_reg.rxcnt + 9'h001);
    assign rx_wr     = (c_reg.st == noproto_pkg::S_RX) & rx_valid;
    // Order 0 sends the upper byte of each word first
    assign body_byte = (c_reg.bi[0] ^ (order_f == 4'h1)) ? mem_lo[c_reg.bi[7:1]]
                                                         : mem_hi[c_reg.bi[7:1]];

    always_comb
    begin
        logic [3:0] c_ord;
        logic [3:0] c_hs;
        logic [3:0] c_port;
        logic [8:0] c_n;
        logic       bad;
        logic       recv;
        logic       end_hit;
        c_next = c_reg;
        c_ord  = pwdata[3:0];
        c_hs   = pwdata[7:4];
        c_port = pwdata[11:8];
        c_n    = pwdata[noproto_pkg::CMD_N +: 9];
        recv   = pwdata[noproto_pkg::CMD_RECV];
        bad    = 1'b0;
        end_hit = 1'b0;
        c_next.ser_start = 1'b0;
        // APB: no wait states, read data captured in the setup cycle
        c_next.pready  = setup;
        c_next.pslverr = 1'b0;
        if (setup)
        begin
            c_next.pslverr = ~(is_buf(paddr) | is_reg(paddr));
            c_next.prdata  = 32'h0000_0000;
            if (is_buf(paddr))
                c_next.prdata = {16'h0000, mem_hi[paddr[8:2]], mem_lo[paddr[8:2]]};
            case (paddr)
                noproto_pkg::CFG_OFS:  c_next.prdata = c_reg.cfg;
                noproto_pkg::BAUD_OFS: c_next.prdata = {16'h0000, c_reg.baud};
                noproto_pkg::GAP_OFS:  c_next.prdata = {16'h0000, c_reg.gap};
                noproto_pkg::CMD_OFS:  c_next.prdata = {7'h00, c_reg.n, c_reg.ctrl};
                noproto_pkg::STAT_OFS: c_next.prdata = {7'h00, c_reg.rxcnt, 13'h0000,
                                                        c_reg.rxdone,
                                                        c_reg.st != noproto_pkg::S_IDLE,
                                                        c_reg.err};
                default: ;
            endcase
        end
        if (wr_acc)
        begin
            case (paddr)
                noproto_pkg::CFG_OFS:  c_next.cfg  = pwdata;
                noproto_pkg::BAUD_OFS: c_next.baud = pwdata[15:0];
                noproto_pkg::GAP_OFS:  c_next.gap  = pwdata[15:0];
                default: ;
            endcase
        end
        // A command while busy is ignored; the status busy bit tells software
        if (cmd_wr && c_reg.st == noproto_pkg::S_IDLE)
        begin
            bad = (c_port > noproto_pkg::PORT_MAX) || (c_ord > noproto_pkg::ORDER_MAX)
               || (c_hs > noproto_pkg::HS_MAX) || (c_n > noproto_pkg::N_MAX);
            if (!bad)
                bad = ~c_reg.cfg[noproto_pkg::CFG_NOPROTO + 32'(c_port[1:0])];
            if (!bad && !recv && c_hs == 4'h0)
                bad = ~send_ready[c_port[1:0]];
            c_next.err    = bad;
            c_next.rxdone = 1'b0;
            if (!bad)
            begin
                c_next.ctrl  = pwdata[15:0];
                c_next.n     = c_n;
                c_next.bi    = 9'h000;
                c_next.tidx  = 1'b0;
                c_next.rxcnt = 9'h000;
                if (recv)
                begin
                    c_next.rxdone = (c_n == 9'h000);
                    c_next.st     = (c_n == 9'h000) ? noproto_pkg::S_IDLE : noproto_pkg::S_RX;
                end
                else
                begin
                    // Handshake lines follow the first source word
                    case (c_hs)
                        noproto_pkg::HS_RS:   c_next.rs[c_port[1:0]] = mem_hi[0][7];
                        noproto_pkg::HS_ER:   c_next.er[c_port[1:0]] = mem_hi[0][7];
                        noproto_pkg::HS_BOTH:
                        begin
                            c_next.rs[c_port[1:0]] = mem_hi[0][7];
                            c_next.er[c_port[1:0]] = mem_hi[0][6];
                        end
                        default: ;
                    endcase
                    if (c_n == 9'h000)
                        c_next.st = noproto_pkg::S_IDLE;
                    else if (c_reg.cfg[noproto_pkg::CFG_SEN])
                        c_next.st = noproto_pkg::S_HEAD;
                    else
                        c_next.st = noproto_pkg::S_BODY;
                end
            end
        end
        case (c_reg.st)
            noproto_pkg::S_HEAD:
                if (can_issue)
                begin
                    c_next.ser_start = 1'b1;
                    c_next.ser_byte  = scode;
                    c_next.st        = noproto_pkg::S_BODY;
                end
            noproto_pkg::S_BODY:
                if (can_issue)
                begin
                    c_next.ser_start = 1'b1;
                    c_next.ser_byte  = body_byte;
                    c_next.bi        = bi_inc;
                    if (bi_inc == c_reg.n)
                        c_next.st = (emode == noproto_pkg::END_NONE) ? noproto_pkg::S_GAP
                                                                    : noproto_pkg::S_TAIL;
                end
            noproto_pkg::S_TAIL:
                if (can_issue)
                begin
                    c_next.ser_start = 1'b1;
                    c_next.tidx      = 1'b1;
                    if (emode == noproto_pkg::END_CRLF)
                    begin
                        c_next.ser_byte = c_reg.tidx ? noproto_pkg::LF_BYTE
                                                     : noproto_pkg::CR_BYTE;
                        if (c_reg.tidx)
                            c_next.st = noproto_pkg::S_GAP;
                    end
                    else
                    begin
                        c_next.ser_byte = ecode;
                        c_next.st       = noproto_pkg::S_GAP;
                    end
                end
            noproto_pkg::S_GAP:
                // Spacing counts from the end of the last stop bit
                if (can_issue)
                begin
                    c_next.gcnt = c_reg.gcnt + 16'h0001;
                    if (c_reg.gcnt >= c_reg.gap)
                    begin
                        c_next.gcnt = 16'h0000;
                        c_next.st   = noproto_pkg::S_IDLE;
                    end
                end
            noproto_pkg::S_RX:
                if (rx_valid)
                begin
                    end_hit = ((emode == noproto_pkg::END_BYTE) && (rx_data == ecode))
                           || ((emode == noproto_pkg::END_CRLF)
                               && (rx_data == noproto_pkg::LF_BYTE));
                    c_next.rxcnt = rx_inc;
                    if (rx_inc == c_reg.n || rx_inc == noproto_pkg::N_MAX || end_hit)
                    begin
                        c_next.rxdone = 1'b1;
                        c_next.st     = noproto_pkg::S_IDLE;
                    end
                end
            default: ;
        endcase
        c_next.txd           = '1;
        c_next.txd[port_sel] = ser_txd;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            c_reg        <= '0;
            c_reg.cfg    <= noproto_pkg::CFG_RST;
            c_reg.baud   <= noproto_pkg::BAUD_DIV_RST;
            c_reg.gap    <= noproto_pkg::GAP_RST;
            c_reg.st     <= noproto_pkg::S_IDLE;
            c_reg.txd    <= '1;
        end
        else
            c_reg <= c_next;
    end

    // Buffer: receive stores take the port over software writes
    always_ff @(posedge clk)
    begin
        if (rx_wr)
        begin
            if (c_reg.rxcnt[0])
                mem_lo[c_reg.rxcnt[7:1]] <= rx_data;
            else
                mem_hi[c_reg.rxcnt[7:1]] <= rx_data;
        end
        else if (wr_acc && is_buf(paddr))
        begin
            mem_hi[paddr[8:2]] <= pwdata[15:8];
            mem_lo[paddr[8:2]] <= pwdata[7:0];
        end
    end

    assign prdata               = c_reg.prdata;
    assign pready               = c_reg.pready;
    assign pslverr              = c_reg.pslverr;
    assign txd                  = c_reg.txd;
    assign rs                   = c_reg.rs;
    assign er                   = c_reg.er;
    assign operation_error_flag = c_reg.err;

    logic [9:0] sent_cnt;
    always_ff @(posedge clk)
    begin
        if (!nrst || cmd_wr)
            sent_cnt <= 10'h000;
        else if (c_reg.ser_start)
            sent_cnt <= sent_cnt + 10'h001;
    end

    property p_line_max;
        @(posedge clk) disable iff (!nrst) sent_cnt <= noproto_pkg::LINE_MAX;
    endproperty
    a_line_max: assert property (p_line_max) else $error("frame too long");

    property p_zero_n;
        @(posedge clk) disable iff (!nrst)
        (cmd_wr && c_reg.st == noproto_pkg::S_IDLE && pwdata[24:16] == 9'h000)
            |=> !c_reg.ser_start [*3];
    endproperty
    a_zero_n: assert property (p_zero_n) else $error("bytes sent for zero count");

    property p_count_err;
        @(posedge clk) disable iff (!nrst)
        (cmd_wr && c_reg.st == noproto_pkg::S_IDLE && pwdata[24:16] > 9'h100)
            |=> operation_error_flag && c_reg.st == noproto_pkg::S_IDLE;
    endproperty
    a_count_err: assert property (p_count_err) else $error("bad count accepted");

    property p_ready_err;
        @(posedge clk) disable iff (!nrst)
        (cmd_wr && c_reg.st == noproto_pkg::S_IDLE && !pwdata[31] && pwdata[7:4] == 4'h0
            && !send_ready[pwdata[9:8]]) |=> operation_error_flag;
    endproperty
    a_ready_err: assert property (p_ready_err) else $error("send without ready");

    property p_hs_bypass;
        @(posedge clk) disable iff (!nrst)
        (cmd_wr && c_reg.st == noproto_pkg::S_IDLE && !pwdata[31] && pwdata[7:4] == 4'h0
            && !send_ready[pwdata[9:8]])
            |=> c_reg.st == noproto_pkg::S_IDLE && !c_reg.ser_start;
    endproperty
    a_hs_bypass: assert property (p_hs_bypass) else $error("send began not ready");

    property p_rs_ctl;
        @(posedge clk) disable iff (!nrst)
        (cmd_wr && c_reg.st == noproto_pkg::S_IDLE && !pwdata[31] && pwdata[7:4] == 4'h1
            && pwdata[11:8] <= 4'h3 && pwdata[3:0] <= 4'h1 && pwdata[24:16] <= 9'h100
            && c_reg.cfg[noproto_pkg::CFG_NOPROTO + 32'(pwdata[9:8])])
            |=> rs[$past(pwdata[9:8])] == $past(mem_hi[0][7]);
    endproperty
    a_rs_ctl: assert property (p_rs_ctl) else $error("RS not from bit 15");

    property p_start_code;
        @(posedge clk) disable iff (!nrst)
        (c_reg.st == noproto_pkg::S_HEAD && can_issue)
            |=> c_reg.ser_start && c_reg.ser_byte == $past(scode);
    endproperty
    a_start_code: assert property (p_start_code) else $error("start code wrong");

    property p_rx_end;
        @(posedge clk) disable iff (!nrst)
        (rx_wr && emode == noproto_pkg::END_BYTE && rx_data == ecode)
            |=> c_reg.rxdone && c_reg.st == noproto_pkg::S_IDLE;
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("end code missed");

    property p_port_idle;
        @(posedge clk) disable iff (!nrst)
        (port_sel != 2'h0) [*2] |-> txd[0];
    endproperty
    a_port_idle: assert property (p_port_idle) else $error("wrong port driven");
endmodule : noproto_serial_send_receive
`default_nettype wire

// ==== tb/serial_peer.sv ====
// Serial peer: decodes 8N1 frames on one line into a byte queue
`timescale 1ns/10ps
`default_nettype none
module serial_peer
#(
    parameter int DIV = 4
)
(
    input wire logic clk,
    input wire logic line
);
    logic [7:0] q[$];
    logic [7:0] b;
    initial
    begin
        forever
        begin
            @(negedge line);
            // Sample mid-bit so a small baud skew still decodes
            repeat (DIV / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(posedge clk);
                b[i] = line;
            end
            repeat (DIV) @(posedge clk);
            q.push_back(b);
        end
    end
endmodule : serial_peer
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the no-protocol serial unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end
module testbench;
    logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, cfg;
    logic        pready, pslverr, rx_valid = 0, flag, se;
    logic [7:0]  rx_data = 0;
    logic [3:0]  send_ready = 4'hF, txd, rs, er;
    logic [1:0]  port = 0;
    logic        ord;
    logic [15:0] w[2];
    int          mismatches = 0, compares = 0, seed = 58;
    noproto_serial_send_receive i_noproto_serial_send_receive (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .send_ready(send_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .txd(txd), .rs(rs), .er(er),
        .operation_error_flag(flag));
    serial_peer #(.DIV(4)) i_serial_peer (.clk(clk), .line(txd[port]));
    initial forever #10 clk = ~clk;
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    // Waits for busy to clear; a hang is left to the watchdog
    task cmd(input logic [31:0] c);
        i_serial_peer.q.delete();
        apb(1, noproto_pkg::CMD_OFS, c);
        do apb(0, noproto_pkg::STAT_OFS, 0); while (r[1] !== 1'b0);
    endtask : cmd
    function logic [7:0] pb(int k);
        return ((k % 2 == 0) == (ord == 0)) ? w[k / 2][15:8] : w[k / 2][7:0];
    endfunction : pb
    task final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    initial
    begin
        #(20 * 20000);
        mismatches++;
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1;
        apb(0, noproto_pkg::CFG_OFS, 0);
        `CHK("cfg", noproto_pkg::CFG_RST, r)
        apb(0, noproto_pkg::BAUD_OFS, 0);
        `CHK("baud", 32'(noproto_pkg::BAUD_DIV_RST), r)
        apb(0, 12'h040, 0);
        `CHK("slverr", 1'b1, se)
        apb(1, noproto_pkg::BAUD_OFS, 4);
        cfg = 32'h0007_83A5 | (32'hF << 19);
        apb(1, noproto_pkg::CFG_OFS, cfg);
        w[0] = 16'($random(seed));
        w[1] = 16'($random(seed));
        apb(1, 12'h200, 32'(w[0]));
        apb(1, 12'h204, 32'(w[1]));
        port = 2'($random(seed));
        ord = 1'($random(seed));
        cmd(32'h0003_0000 | (32'(port) << 8) | 32'(ord));
        `CHK("err", 1'b0, flag)
        `CHK("count", 6, i_serial_peer.q.size())
        `CHK("start", 8'hA5, i_serial_peer.q[0])
        for (int k = 0; k < 3; k++)
            `CHK("payload", pb(k), i_serial_peer.q[k + 1])
        `CHK("cr", 8'h0D, i_serial_peer.q[4])
        `CHK("lf", 8'h0A, i_serial_peer.q[5])
        $display("send test done");
        foreach (w[i])
        begin
            cmd(i ? 32'h0101_0000 : 32'h0000_0402); // bad N, bad port
            `CHK("bad", 1'b1, flag)
        end
        cmd(32'h0001_0002);
        `CHK("order", 1'b1, flag)
        `CHK("none", 0, i_serial_peer.q.size())
        cmd(32'h0000_0000 | (32'(port) << 8));
        `CHK("zero", 0, i_serial_peer.q.size())
        `CHK("zero err", 1'b0, flag)
        send_ready <= 0;
        cmd(32'h0001_0000 | (32'(port) << 8));
        `CHK("ready", 1'b1, flag)
        `CHK("held", 0, i_serial_peer.q.size())
        // Ports here all carry both lines, so every handshake value is legal
        for (int h = 1; h < 4; h++)
        begin
            cmd(32'h0001_0000 | (32'(port) << 8) | (32'(h) << 4));
            `CHK("hs", 1'b0, flag)
            `CHK("hs sent", 4, i_serial_peer.q.size())
            if (h != 2) `CHK("rs", w[0][15], rs[port])
            if (h != 1) `CHK("er", h == 2 ? w[0][15] : w[0][14], er[port])
        end
        send_ready <= 4'hF;
        apb(1, noproto_pkg::CFG_OFS, 0);
        cmd(32'h0001_0000 | (32'(port) << 8));
        `CHK("mode", 1'b1, flag)
        $display("error test done");
        // Pass 0 ends on the count; pass 1 asks for 3 but stops on end code F0
        for (int m = 0; m < 2; m++)
        begin
            apb(1, noproto_pkg::CFG_OFS, (cfg & 32'hFFFF_F9FF) | (32'(m) << 10));
            apb(1, noproto_pkg::CMD_OFS, 32'h8002_0000 | (32'(m) << 16) | (32'(port) << 8));
            foreach (w[i])
            begin
                @(posedge clk);
                rx_valid <= 1;
                rx_data <= m ? (i ? 8'hF0 : 8'h0F) : w[1][15 - 8 * i -: 8];
                @(posedge clk);
                rx_valid <= 0;
            end
            apb(0, noproto_pkg::STAT_OFS, 0);
            `CHK("rxdone", 1'b1, r[2])
            `CHK("rxcnt", 9'h002, r[24:16])
            apb(0, 12'h200, 0);
            `CHK("rxword", m ? 16'h0FF0 : w[1], r[15:0])
        end
        $display("receive test done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
